// file: testbench/cca_pin_model.sv
// partner model: outside source on the channel pin and the resolved pin level
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
  input  wire logic clk_in,
  input  wire logic dut_drive_in,
  input  wire logic dut_oe_n_in,
  output wire logic pin_level_out
);
  logic src_reg;

  initial src_reg = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // the module owns the wire while its active-low enable is low
  assign pin_level_out = dut_oe_n_in ? src_reg : dut_drive_in;

  ////////////////////////////////////////////////////////////////////////////
  // new level just after an edge, then held; hold 0 makes a one-cycle glitch
  task automatic put(input logic level, input int hold);
    @(posedge clk_in);
    src_reg <= level;
    repeat (hold) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// file: testbench/test_cca_module.sv
// self-checking bench for one capture/compare channel
`timescale 1ns/1ps
`default_nettype none
module test_cca_module;
  logic        clk_in    = 1'b0;
  logic        rst_in    = 1'b1;
  logic        reg_wr    = 1'b0;
  logic [1:0]  reg_idx   = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        gie       = 1'b0;
  logic        aie       = 1'b0;
  logic        run       = 1'b0;
  logic        tick      = 1'b0;
  logic        ovf_clr   = 1'b0;
  logic        pin_level;
  logic        pin_drv;
  logic        oe_n;
  logic        flag;
  logic        pin_state;
  logic        irq;
  logic        ovf;
  logic [7:0]  mode;
  logic [7:0]  cap_lo;
  logic [7:0]  cap_hi;
  logic [15:0] count;
  logic [15:0] cnt       = 16'h0000;
  int          mismatches      = 0;
  int          samples_checked = 0;

  always #4 clk_in = ~clk_in;

  cca_module dut (
    .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr), .reg_idx_in(reg_idx),
    .reg_wdata_in(reg_wdata), .global_irq_enable_in(gie), .array_irq_enable_in(aie),
    .count_run_in(run), .count_tick_in(tick), .ovf_clear_in(ovf_clr),
    .channel_pin_in(pin_level), .channel_pin_out(pin_drv), .channel_pin_oe_n_out(oe_n),
    .mode_reg_out(mode), .cap_low_out(cap_lo), .cap_high_out(cap_hi), .flag_out(flag),
    .pin_state_out(pin_state), .irq_out(irq), .count_out(count), .ovf_flag_out(ovf)
  );

  cca_pin_model pm (
    .clk_in(clk_in), .dut_drive_in(pin_drv), .dut_oe_n_in(oe_n), .pin_level_out(pin_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [1:0] idx, input logic [7:0] data);
    @(posedge clk_in);
    reg_wr    <= 1'b1;
    reg_idx   <= idx;
    reg_wdata <= data;
    @(posedge clk_in);
    reg_wr    <= 1'b0;
  endtask

  // low byte first so compare stays off until both bytes are in place
  task automatic set_cmp(input logic [15:0] v);
    wr(cca_pkg::REG_CPL, v[7:0]);
    wr(cca_pkg::REG_CPH, v[15:8]);
  endtask

  // n back-to-back counter steps, tracked in cnt
  task automatic ticks(input int n);
    if (n > 0) begin
      @(posedge clk_in);
      tick <= 1'b1;
      repeat (n) @(posedge clk_in);
      tick <= 1'b0;
      cnt = cnt + 16'(n);
    end
  endtask

  // sample at the falling edge so clocked updates have landed
  task automatic settle(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  function automatic int dist8(input logic [7:0] t);
    logic [7:0] d;
    d = t - cnt[7:0];
    return (d == 8'h00) ? 256 : int'(d);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    @(negedge clk_in);
    check(16'(mode), 16'(cca_pkg::MODE_RESET), "mode after reset");
    check({cap_hi, cap_lo}, cca_pkg::COUNT_ZERO, "compare after reset");
    check(count, cca_pkg::COUNT_ZERO, "counter after reset");
    check(16'({flag, irq, ovf, oe_n, pin_drv}), 16'h0002, "status after reset");
  endtask

  task automatic t_regs;
    wr(cca_pkg::REG_MODE, 8'h49);
    wr(cca_pkg::REG_CPL, 8'h34);
    settle(0);
    check(16'(mode), 16'h0009, "low byte write clears enable");
    wr(cca_pkg::REG_CPH, 8'h12);
    settle(0);
    check(16'(mode), 16'h0049, "high byte write sets enable");
    check({cap_hi, cap_lo}, 16'h1234, "compare bytes");
  endtask

  task automatic t_timer;
    set_cmp(cnt + 16'h0005);
    gie <= 1'b1;
    aie <= 1'b1;
    ticks(4);
    settle(2);
    check(16'(flag), 16'h0000, "timer flag early");
    ticks(1);
    settle(2);
    check(16'(flag), 16'h0001, "timer flag on match");
    check(16'(irq), 16'h0001, "request with all enables");
    @(posedge clk_in);
    gie <= 1'b0;
    settle(2);
    check(16'(irq), 16'h0000, "request with global off");
    @(posedge clk_in);
    gie <= 1'b1;
    aie <= 1'b0;
    settle(2);
    check(16'(irq), 16'h0000, "request with array off");
    ticks(3);
    settle(2);
    check(16'(flag), 16'h0001, "flag stays set");
    wr(cca_pkg::REG_MODE, 8'h48);
    aie <= 1'b1;
    settle(2);
    check(16'(irq), 16'h0000, "request with flag irq off");
    wr(cca_pkg::REG_FLAG, 8'h00);
    set_cmp(cnt + 16'h0002);
    wr(cca_pkg::REG_MODE, 8'h69);
    ticks(2);
    settle(2);
    check(16'(flag), 16'h0000, "no timer with capture bit");
  endtask

  task automatic t_hso;
    logic p;
    set_cmp(cnt + 16'h0003);
    wr(cca_pkg::REG_MODE, 8'h4c);
    settle(1);
    p = pin_drv;
    check(16'(oe_n), 16'h0000, "hso drives pin");
    ticks(2);
    settle(2);
    check(16'(pin_drv), 16'(p), "hso before match");
    ticks(1);
    settle(2);
    check(16'(pin_drv), 16'(!p), "hso toggle");
  endtask

  task automatic t_freq;
    logic       p;
    logic [7:0] l;
    l = cnt[7:0] + 8'h02;
    wr(cca_pkg::REG_CPL, l);
    wr(cca_pkg::REG_CPH, 8'h05);
    wr(cca_pkg::REG_MODE, 8'h4e);
    settle(1);
    p = pin_drv;
    ticks(2);
    settle(2);
    check(16'(pin_drv), 16'(!p), "freq first toggle");
    check(16'(cap_lo), 16'(l + 8'h05), "freq step added");
    ticks(4);
    settle(2);
    check(16'(pin_drv), 16'(!p), "freq between toggles");
    ticks(1);
    settle(2);
    check(16'(pin_drv), 16'(p), "freq second toggle");
    check(16'(cap_lo), 16'(l + 8'h0a), "freq second step");
    wr(cca_pkg::REG_CPH, 8'h00);
    ticks(5);
    settle(2);
    check(16'(pin_drv), 16'(!p), "freq zero step toggle");
    ticks(255);
    settle(2);
    check(16'(pin_drv), 16'(!p), "zero step one short");
    ticks(1);
    settle(2);
    check(16'(pin_drv), 16'(p), "zero step is 256");
  endtask

  task automatic t_pwm8;
    wr(cca_pkg::REG_CPL, 8'h40);
    wr(cca_pkg::REG_CPH, 8'hc0);
    wr(cca_pkg::REG_MODE, 8'h42);
    ticks(dist8(8'h40));
    settle(2);
    check(16'({oe_n, pin_drv}), 16'h0001, "pwm8 set on match");
    ticks(dist8(8'h00));
    settle(2);
    check(16'(pin_drv), 16'h0000, "pwm8 clear on overflow");
    check(16'(cap_lo), 16'h00c0, "pwm8 reload");
    ticks(dist8(8'hc0));
    settle(2);
    check(16'(pin_drv), 16'h0001, "pwm8 set at reloaded value");
    wr(cca_pkg::REG_CPL, 8'h55);
    ticks(dist8(8'hd0));
    settle(2);
    check(16'(pin_level), 16'h0000, "pwm8 held low");
  endtask

  task automatic t_wide_pulse_select;
    set_cmp(cnt + 16'h0010);
    wr(cca_pkg::REG_MODE, 8'hcb); // match interrupts on
    wr(cca_pkg::REG_FLAG, 8'h00);
    ticks(16);
    settle(2);
    check(16'({pin_drv, flag, ovf}), 16'h0006, "wide_pulse_select set on match");
    ticks(65536 - int'(cnt));
    settle(2);
    check(16'(pin_drv), 16'h0000, "wide_pulse_select clear on overflow");
    check(count, cca_pkg::COUNT_ZERO, "counter wrapped");
    check(16'(ovf), 16'h0001, "overflow flag set");
    @(posedge clk_in);
    ovf_clr <= 1'b1;
    @(posedge clk_in);
    ovf_clr <= 1'b0;
    settle(1);
    check(16'(ovf), 16'h0000, "overflow flag cleared");
  endtask

  task automatic t_capture;
    logic [7:0] m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h20 : (i == 1) ? 8'h10 : 8'h30;
      wr(cca_pkg::REG_MODE, m);
      settle(8);
      check(16'(oe_n), 16'h0001, "capture leaves pin free");
      wr(cca_pkg::REG_FLAG, 8'h00);
      ticks(3);
      pm.put(1'b1, 8);
      @(negedge clk_in);
      check(16'(flag), 16'(m[5]), "rising capture");
      if (m[5])
        check({cap_hi, cap_lo}, cnt, "rising value");
      if (m[5] & m[4])
        check(16'(pin_state), 16'h0001, "level after rise");
      wr(cca_pkg::REG_FLAG, 8'h00);
      ticks(3);
      pm.put(1'b0, 8);
      @(negedge clk_in);
      check(16'(flag), 16'(m[4]), "falling capture");
      if (m[4])
        check({cap_hi, cap_lo}, cnt, "falling value");
      if (m[5] & m[4])
        check(16'(pin_state), 16'h0000, "level after fall");
    end
    // a one-cycle pulse is too short to be seen
    wr(cca_pkg::REG_MODE, 8'h20);
    wr(cca_pkg::REG_FLAG, 8'h00);
    pm.put(1'b1, 0);
    pm.put(1'b0, 8);
    @(negedge clk_in);
    check(16'(flag), 16'h0000, "glitch ignored");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    run    <= 1'b1;
    t_reset;
    t_regs;
    t_timer;
    t_hso;
    t_freq;
    t_pwm8;
    t_wide_pulse_select;
    t_capture;
    test_done;
  end

  initial begin
    #720000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire

// file: verilog/cca_counter.sv
// shared 16-bit counter with sticky overflow flag
`timescale 1ns/1ps
`default_nettype none
module cca_counter (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic        tick_in,
  input  wire logic        ovf_clear_in,
  output logic [15:0]      count_out,
  output logic             step_out,
  output logic             ovf_flag_out
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        step_reg;
  logic        step_next;
  logic        ovf_reg;
  logic        ovf_next;

  ////////////////////////////////////////////////////////////////////////////
  // count on each timebase tick while run is high; overflow set wins over a software clear
  always_comb begin
    count_next = count_reg;
    step_next  = run_in && tick_in;
    ovf_next   = ovf_clear_in ? 1'b0 : ovf_reg;
    if (run_in && tick_in) begin
      count_next = count_reg + 16'h0001;
      if (count_reg == cca_pkg::COUNT_MAX) begin
        ovf_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_reg <= cca_pkg::COUNT_ZERO;
      step_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      step_reg  <= step_next;
      ovf_reg   <= ovf_next;
    end
  end

  assign count_out    = count_reg;
  assign step_out     = step_reg;
  assign ovf_flag_out = ovf_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_wrap_sets_ovf: assert property (@(posedge clk_in) disable iff (rst_in)
    (run_in && tick_in && count_reg == cca_pkg::COUNT_MAX)
      |=> (count_reg == cca_pkg::COUNT_ZERO) && ovf_reg)
    else $error("counter wrap did not clear count and set overflow");
endmodule
`default_nettype wire

// file: verilog/cca_module.sv
// one capture/compare channel with its shared counter and register port
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - capture mode captures on rising, falling or both pin edges per two bits.
// - a valid capture edge copies the counter into both bytes and sets the flag.
// - a pin level counts only after it has been held two clock cycles.
// - with both edge bits set software reads the pin level directly.
// - software timer mode is compare enable plus match, other modes clear.
// - timer mode sets the flag when counter equals the 16-bit compare value.
// - high-speed output toggles the pin on every 16-bit compare match.
// - frequency output needs compare enable, toggle and pwm, wide bit clear.
// - frequency output toggles on low byte match and adds high to low.
// - a zero high-byte step yields 256 counts between toggles.
// - 8-bit pwm is compare enable plus pwm, wide, toggle, capture bits clear.
// - 8-bit pwm sets pin on low byte match, clears it on overflow.
// - in 8-bit pwm, on low byte rollover the low compare byte reloads from the high byte.
// - 16-bit pwm is compare enable, pwm and wide bits, toggle and captures clear.
// - 16-bit pwm sets pin on full match, clears it on counter overflow.
// - pwm with compare enable clear holds the pin low.
// - low byte write clears compare enable, high byte write sets it.
// - the flag raises a request only with the flag interrupt enable set.
// - requests reach the cpu only with global and array enables both set.
// - hardware never clears the flag; only software does.
// - the shared counter wraps to zero and sets an overflow flag.
module cca_module (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        reg_wr_in,
  input  wire logic [1:0]  reg_idx_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        global_irq_enable_in,
  input  wire logic        array_irq_enable_in,
  input  wire logic        count_run_in,
  input  wire logic        count_tick_in,
  input  wire logic        ovf_clear_in,
  input  wire logic        channel_pin_in,
  output logic             channel_pin_out,
  output logic             channel_pin_oe_n_out,
  output logic [7:0]       mode_reg_out,
  output logic [7:0]       cap_low_out,
  output logic [7:0]       cap_high_out,
  output logic             flag_out,
  output logic             pin_state_out,
  output logic             irq_out,
  output logic [15:0]      count_out,
  output logic             ovf_flag_out
);
  // decode the mode bits into one operating mode
  function automatic cca_pkg::cca_mode_t mode_of(input logic [7:0] m);
    logic compare_enable, rise, fall, match_enable, toggle_enable, pwm, wide;
    compare_enable = m[cca_pkg::BIT_COMPARE_ENABLE];
    rise = m[cca_pkg::BIT_RISE];
    fall = m[cca_pkg::BIT_FALL];
    match_enable  = m[cca_pkg::BIT_MATCH];
    toggle_enable  = m[cca_pkg::BIT_TOGGLE];
    pwm  = m[cca_pkg::BIT_PWM];
    wide = m[cca_pkg::BIT_WIDE];
    mode_of = cca_pkg::CCA_OFF;
    if ((rise || fall) && !match_enable && !toggle_enable && !pwm) begin
      mode_of = cca_pkg::CCA_CAPTURE;
    end else if (rise || fall) begin
      mode_of = cca_pkg::CCA_OFF;
    end else if (match_enable && !toggle_enable && !pwm && compare_enable) begin
      mode_of = cca_pkg::CCA_TIMER;
    end else if (match_enable && toggle_enable && !pwm && compare_enable) begin
      mode_of = cca_pkg::CCA_HSO;
    end else if (toggle_enable && pwm && !wide) begin
      mode_of = cca_pkg::CCA_FREQ;
    end else if (pwm && !toggle_enable && !wide) begin
      mode_of = cca_pkg::CCA_PWM8;
    end else if (pwm && !toggle_enable && wide) begin
      mode_of = cca_pkg::CCA_WIDE_PULSE_SELECT;
    end
  endfunction

  logic [15:0] count_w;
  logic        step_w;
  logic        ovf_w;

  ////////////////////////////////////////////////////////////////////////////
  // shared counter
  cca_counter u_counter (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .run_in       (count_run_in),
    .tick_in      (count_tick_in),
    .ovf_clear_in (ovf_clear_in),
    .count_out    (count_w),
    .step_out     (step_w),
    .ovf_flag_out (ovf_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and edge detection
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic level_next;
  logic level_d_reg;

  // level moves only once two synchronised samples agree: shorter pulses are lost
  always_comb begin
    level_next = level_reg;
    if (sync2_reg == sync3_reg) begin
      level_next = sync3_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      sync3_reg   <= 1'b0;
      level_reg   <= 1'b0;
      level_d_reg <= 1'b0;
    end else begin
      sync1_reg   <= channel_pin_in;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      level_reg   <= level_next;
      level_d_reg <= level_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode, compare and flag state
  logic [7:0]        mode_reg;
  logic [7:0]        mode_next;
  logic [7:0]        cpl_reg;
  logic [7:0]        cpl_next;
  logic [7:0]        cph_reg;
  logic [7:0]        cph_next;
  logic              flag_reg;
  logic              flag_next;
  logic              pin_reg;
  logic              pin_next;
  logic              oe_n_reg;
  logic              oe_n_next;
  logic              irq_reg;
  logic              irq_next;
  logic              pstate_reg;
  cca_pkg::cca_mode_t mode_w;
  logic              rise_edge;
  logic              fall_edge;
  logic              cap_event;
  logic              match16;
  logic              match8;
  logic              low_wrap;
  logic              compare_enable_w;

  assign mode_w    = mode_of(mode_reg);
  assign compare_enable_w    = mode_reg[cca_pkg::BIT_COMPARE_ENABLE];
  assign rise_edge = level_reg && !level_d_reg;
  assign fall_edge = !level_reg && level_d_reg;
  assign cap_event = (mode_w == cca_pkg::CCA_CAPTURE) &&
                     ((rise_edge && mode_reg[cca_pkg::BIT_RISE]) ||
                      (fall_edge && mode_reg[cca_pkg::BIT_FALL]));
  // match only on counter step cycles, so a stopped counter cannot fire again
  assign match16   = step_w && (count_w == {cph_reg, cpl_reg});
  assign match8    = step_w && (count_w[7:0] == cpl_reg);
  assign low_wrap  = step_w && (count_w[7:0] == cca_pkg::BYTE_ZERO);

  // next values; a software write to a compare byte wins over a capture
  always_comb begin
    mode_next = mode_reg;
    cpl_next  = cpl_reg;
    cph_next  = cph_reg;
    flag_next = flag_reg;
    pin_next  = pin_reg;
    oe_n_next = 1'b1;
    case (mode_w)
      cca_pkg::CCA_CAPTURE: begin
        if (cap_event) begin
          cpl_next  = count_w[7:0];
          cph_next  = count_w[15:8];
        end
      end
      cca_pkg::CCA_HSO: begin
        oe_n_next = 1'b0;
        if (match16) begin
          pin_next = !pin_reg;
        end
      end
      cca_pkg::CCA_FREQ: begin
        oe_n_next = 1'b0;
        if (compare_enable_w && match8) begin
          pin_next = !pin_reg;
          cpl_next = cpl_reg + cph_reg;
        end
      end
      cca_pkg::CCA_PWM8: begin
        oe_n_next = 1'b0;
        if (low_wrap) begin
          cpl_next = cph_reg;
          pin_next = (cph_reg == cca_pkg::BYTE_ZERO);
        end else if (match8) begin
          pin_next = 1'b1;
        end
        if (!compare_enable_w) begin
          pin_next = 1'b0;
        end
      end
      cca_pkg::CCA_WIDE_PULSE_SELECT: begin
        oe_n_next = 1'b0;
        if (step_w && count_w == cca_pkg::COUNT_ZERO) begin
          pin_next = ({cph_reg, cpl_reg} == cca_pkg::COUNT_ZERO);
        end else if (match16) begin
          pin_next = 1'b1;
        end
        if (!compare_enable_w) begin
          pin_next = 1'b0;
        end
      end
      default: begin
        oe_n_next = 1'b1;
      end
    endcase
    // software register writes
    if (reg_wr_in) begin
      case (reg_idx_in)
        cca_pkg::REG_MODE: begin
          mode_next = reg_wdata_in;
        end
        cca_pkg::REG_CPL: begin
          cpl_next = reg_wdata_in;
          mode_next[cca_pkg::BIT_COMPARE_ENABLE] = 1'b0;
        end
        cca_pkg::REG_CPH: begin
          cph_next = reg_wdata_in;
          mode_next[cca_pkg::BIT_COMPARE_ENABLE] = 1'b1;
        end
        cca_pkg::REG_FLAG: begin
          flag_next = reg_wdata_in[cca_pkg::BIT_FLAG];
        end
        default: begin
          flag_next = flag_next;
        end
      endcase
    end
    // hardware only ever sets the flag, and a set beats a same-cycle clear
    if (cap_event) begin
      flag_next = 1'b1;
    end
    if (compare_enable_w && mode_reg[cca_pkg::BIT_MATCH] && mode_w != cca_pkg::CCA_OFF &&
        ((match16 && mode_w != cca_pkg::CCA_FREQ && mode_w != cca_pkg::CCA_PWM8) ||
         (match8 && (mode_w == cca_pkg::CCA_FREQ || mode_w == cca_pkg::CCA_PWM8)))) begin
      flag_next = 1'b1;
    end
    irq_next = flag_reg && mode_reg[cca_pkg::BIT_IRQEN] &&
               global_irq_enable_in && array_irq_enable_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_reg   <= cca_pkg::MODE_RESET;
      cpl_reg    <= cca_pkg::BYTE_ZERO;
      cph_reg    <= cca_pkg::BYTE_ZERO;
      flag_reg   <= 1'b0;
      pin_reg    <= 1'b0;
      oe_n_reg   <= 1'b1;
      irq_reg    <= 1'b0;
      pstate_reg <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      cpl_reg    <= cpl_next;
      cph_reg    <= cph_next;
      flag_reg   <= flag_next;
      pin_reg    <= pin_next;
      oe_n_reg   <= oe_n_next;
      irq_reg    <= irq_next;
      pstate_reg <= level_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign channel_pin_out      = pin_reg;
  assign channel_pin_oe_n_out = oe_n_reg;
  assign mode_reg_out         = mode_reg;
  assign cap_low_out          = cpl_reg;
  assign cap_high_out         = cph_reg;
  assign flag_out             = flag_reg;
  assign pin_state_out        = pstate_reg;
  assign irq_out              = irq_reg;
  assign count_out            = count_w;
  assign ovf_flag_out         = ovf_w;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_pwm_idle;
    (mode_w == cca_pkg::CCA_PWM8 || mode_w == cca_pkg::CCA_WIDE_PULSE_SELECT) && !compare_enable_w && !reg_wr_in;
  endsequence
  sequence s_freq_hit;
    (mode_w == cca_pkg::CCA_FREQ) && compare_enable_w && match8 && !reg_wr_in;
  endsequence
  a_low_write_clear: assert property (reg_wr_in && reg_idx_in == cca_pkg::REG_CPL
    |=> !mode_reg[cca_pkg::BIT_COMPARE_ENABLE] && cpl_reg == $past(reg_wdata_in))
    else $error("low byte write did not clear compare enable");
  a_high_write_set: assert property (reg_wr_in && reg_idx_in == cca_pkg::REG_CPH
    |=> mode_reg[cca_pkg::BIT_COMPARE_ENABLE] && cph_reg == $past(reg_wdata_in))
    else $error("high byte write did not set compare enable");
  a_flag_sticky: assert property (flag_reg && !(reg_wr_in && reg_idx_in == cca_pkg::REG_FLAG)
    |=> flag_reg)
    else $error("flag cleared without software");
  a_irq_gate: assert property (irq_reg
    |-> $past(flag_reg && mode_reg[cca_pkg::BIT_IRQEN] &&
              global_irq_enable_in && array_irq_enable_in))
    else $error("interrupt raised without all enables");
  a_capture_load: assert property (cap_event && !reg_wr_in
    |=> {cph_reg, cpl_reg} == $past(count_w) && flag_reg)
    else $error("capture did not load counter and flag");
  a_level_filter: assert property ($changed(level_reg)
    |-> $past(sync2_reg == sync3_reg) && level_reg == $past(sync3_reg))
    else $error("pin level accepted before two agreeing samples");
  a_pwm_off_low: assert property (s_pwm_idle [*2] |-> !pin_reg)
    else $error("pwm with compare disabled did not hold pin low");
  a_hso_toggle: assert property ((mode_w == cca_pkg::CCA_HSO) && match16
    |=> pin_reg != $past(pin_reg))
    else $error("high-speed output did not toggle on match");
  a_timer_flag: assert property ((mode_w == cca_pkg::CCA_TIMER) && match16
    |=> flag_reg)
    else $error("timer match did not set flag");
  a_freq_step: assert property (s_freq_hit
    |=> cpl_reg == 8'($past(cpl_reg) + $past(cph_reg)) && pin_reg != $past(pin_reg))
    else $error("frequency output did not toggle and advance");
  a_pwm8_reload: assert property ((mode_w == cca_pkg::CCA_PWM8) && low_wrap && !reg_wr_in
    |=> cpl_reg == $past(cph_reg))
    else $error("8-bit pwm did not reload low byte");
endmodule
`default_nettype wire

// file: verilog/cca_pkg.sv
// constants and types shared by the capture/compare module and its counter
package cca_pkg;
  // register indices on the special function register port
  localparam logic [1:0] REG_MODE  = 2'h0;
  localparam logic [1:0] REG_CPL   = 2'h1;
  localparam logic [1:0] REG_CPH   = 2'h2;
  localparam logic [1:0] REG_FLAG  = 2'h3;

  // module_mode_control bit positions, and the flag bit of the flag register
  localparam int BIT_WIDE   = 7;
  localparam int BIT_COMPARE_ENABLE   = 6;
  localparam int BIT_RISE   = 5;
  localparam int BIT_FALL   = 4;
  localparam int BIT_MATCH  = 3;
  localparam int BIT_TOGGLE = 2;
  localparam int BIT_PWM    = 1;
  localparam int BIT_IRQEN  = 0;
  localparam int BIT_FLAG   = 0;

  // reset values and the counter's top value
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // decoded operating mode, one-hot
  typedef enum logic [6:0] {
    CCA_OFF     = 7'h01,
    CCA_CAPTURE = 7'h02,
    CCA_TIMER   = 7'h04,
    CCA_HSO     = 7'h08,
    CCA_FREQ    = 7'h10,
    CCA_PWM8    = 7'h20,
    CCA_WIDE_PULSE_SELECT   = 7'h40
  } cca_mode_t;
endpackage
